// >>> scan_sensor.sv
// Sensor end: timing generator, integration counter, strobe and end-of-scan outputs.
`timescale 1ns/10ps
`default_nettype none
module scan_sensor #(
  parameter int PIXELS = scan_pkg::PIXEL_COUNT
) (
  input  wire logic mclk,           // Scan clock.
  input  wire logic rst_n,          // Synchronous active-low reset.
  scan_link_if.sensor link,         // Link to the controller.
  output var  logic [scan_pkg::CNT_W-1:0] integTime, // Last integration time, clocks.
  output var  logic                       integDone  // Pulse when a new time is posted.
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_HIGH = 3'b010,
    S_SHIFT = 3'b100
  } sens_state_t;

  localparam int LAST_STEP = scan_pkg::FIRST_VALID - 1 + PIXELS;

  sens_state_t                 state_ff, nxt_state;
  logic                        start_ff;
  logic [scan_pkg::CNT_W-1:0]  highCnt_ff;
  logic [scan_pkg::CNT_W-1:0]  step_ff;
  logic [scan_pkg::CNT_W-1:0]  integ_ff;
  logic                        integDone_ff;
  logic                        trig_ff;
  logic                        eos_ff;
  logic [scan_pkg::SAMPLE_W-1:0] video_ff;

  wire startRise = link.scanStartPulse && !start_ff;
  wire startFall = !link.scanStartPulse && start_ff;
  wire lastStep   = (step_ff == scan_pkg::CNT_W'(LAST_STEP));
  wire endNext    = (step_ff == scan_pkg::CNT_W'(LAST_STEP - 1));
  wire shiftNext  = (nxt_state == S_SHIFT);
  wire pixelPhase = (step_ff >= scan_pkg::CNT_W'(scan_pkg::FIRST_VALID - 1));

  // Next state: high while the start pulse is up, then shifting until all pixels are out.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (startRise) nxt_state = S_HIGH;
      S_HIGH:  if (startFall) nxt_state = S_SHIFT;
      S_SHIFT: begin
        if (startRise) nxt_state = S_HIGH;
        else if (lastStep) nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Timing generator registers; a new start pulse aborts and restarts the scan.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      start_ff     <= 1'b0;
      highCnt_ff   <= '0;
      step_ff      <= '0;
      integ_ff     <= '0;
      integDone_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      start_ff     <= link.scanStartPulse;
      integDone_ff <= 1'b0;
      if (startRise) begin
        highCnt_ff <= scan_pkg::CNT_W'(1);
      end else if (state_ff == S_HIGH && link.scanStartPulse) begin
        highCnt_ff <= highCnt_ff + scan_pkg::CNT_W'(1);
      end
      if (state_ff == S_HIGH && startFall) begin
        integ_ff     <= highCnt_ff + scan_pkg::CNT_W'(scan_pkg::INTEG_EXTRA);
        integDone_ff <= 1'b1;
        step_ff      <= scan_pkg::CNT_W'(1);
      end else if (state_ff == S_SHIFT && !lastStep) begin
        step_ff <= step_ff + scan_pkg::CNT_W'(1);
      end else begin
        step_ff <= '0;
      end
    end
  end

  // Link outputs: one strobe per shift step, and the end flag rides on the last strobe.
  // Outputs are computed from the step before the edge, so strobe fifty carries pixel zero.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trig_ff  <= 1'b0;
      eos_ff   <= 1'b0;
      video_ff <= '0;
    end else begin
      trig_ff  <= shiftNext;
      eos_ff   <= shiftNext && endNext;
      video_ff <= (shiftNext && pixelPhase) ?
                  scan_pkg::SAMPLE_W'(step_ff - scan_pkg::CNT_W'(scan_pkg::FIRST_VALID - 1)) : '0;
    end
  end

  assign link.trigStrobe  = trig_ff;
  assign link.scanEndFlag = eos_ff;
  assign link.video       = video_ff;
  assign integTime        = integ_ff;
  assign integDone        = integDone_ff;
endmodule
`default_nettype wire

// >>> scan_pkg.sv
// Shared constants for the linear sensor scan timing link.
package scan_pkg;
  localparam int PIXEL_COUNT    = 2496; // Pixels read out per scan.
  localparam int START_HIGH_MIN = 6;    // Least start-pulse high period, clocks.
  localparam int START_LOW_MIN  = 64;   // Least start-pulse low period, clocks.
  localparam int START_CYC_MIN  = 70;   // Least start-pulse period, clocks.
  localparam int INTEG_EXTRA    = 34;   // Clocks added to the high period for integration.
  localparam int FIRST_VALID    = 50;   // Strobe number of the first valid sample.
  localparam int SCAN_PERIOD    = 2548; // Default controller period; reading every pixel takes 2551 at the high minimum.
  localparam int SAMPLE_W       = 12;   // Width of one digitised video sample.
  localparam int FIFO_DEPTH     = 4;    // Words buffered on the controller side.
  localparam int CNT_W          = 16;   // Width of the scan and period counters.
endpackage

// >>> scan_link_if.sv
// Interface joining the sensor end and the readout controller end.
`timescale 1ns/10ps
`default_nettype none
interface scan_link_if;
  logic                         scanStartPulse; // Start pulse from the controller.
  logic                         trigStrobe;     // Per-pixel sample strobe from the sensor.
  logic                         scanEndFlag;    // End-of-scan flag from the sensor.
  logic [scan_pkg::SAMPLE_W-1:0] video;         // Digitised video sample.
  modport sensor (input scanStartPulse, output trigStrobe, output scanEndFlag, output video);
  modport ctrl   (output scanStartPulse, input trigStrobe, input scanEndFlag, input video);
endinterface
`default_nettype wire

// >>> scan_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module scan_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,     // System clock.
  input  wire logic             rst_n,    // Synchronous active-low reset.
  input  wire logic             inValid,  // Write request.
  output var  logic             inReady,  // Space available.
  input  wire logic [WIDTH-1:0] inData,   // Write data.
  output var  logic             outValid, // Data available.
  input  wire logic             outReady, // Drain accepts data.
  output var  logic [WIDTH-1:0] outData   // Read data.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  wire              doWr = inValid && inReady;
  wire              doRd = outValid && outReady;

  // Full and empty come straight from the occupancy count.
  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWr) begin
        mem[wrPtr_ff] <= inData;
        wrPtr_ff      <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + AW'(1);
      end
      if (doRd) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + AW'(1);
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + (AW+1)'(1);
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> scan_ctrl.sv
// Controller end: start-pulse generator and video capture into a FIFO.
`timescale 1ns/10ps
`default_nettype none
module scan_ctrl #(
  parameter int PERIOD = scan_pkg::SCAN_PERIOD,
  parameter int PIXELS = scan_pkg::PIXEL_COUNT
) (
  input  wire logic mclk,                              // Scan clock.
  input  wire logic rst_n,                             // Synchronous active-low reset.
  scan_link_if.ctrl link,                              // Link to the sensor.
  input  wire logic                       enable,      // Run scans while high.
  input  wire logic [scan_pkg::CNT_W-1:0] lowTime,     // Requested low period, clocks.
  output var  logic [scan_pkg::SAMPLE_W-1:0] pixData,  // Captured sample.
  output var  logic                       pixValid,    // Sample available.
  input  wire logic                       pixReady,    // Consumer takes the sample.
  output var  logic                       overflow     // Sticky: a sample was dropped.
);
  localparam logic [scan_pkg::CNT_W-1:0] HIGH_MIN = scan_pkg::CNT_W'(scan_pkg::START_HIGH_MIN);
  localparam logic [scan_pkg::CNT_W-1:0] LOW_MIN  = scan_pkg::CNT_W'(scan_pkg::START_LOW_MIN);
  localparam logic [scan_pkg::CNT_W-1:0] PER      = scan_pkg::CNT_W'(PERIOD < scan_pkg::START_CYC_MIN ?
                                                    scan_pkg::START_CYC_MIN : PERIOD);

  logic [scan_pkg::CNT_W-1:0] phase_ff;
  logic [scan_pkg::CNT_W-1:0] lowLatch_ff;
  logic [scan_pkg::CNT_W-1:0] trigCnt_ff;
  logic                       start_ff;
  logic                       over_ff;
  logic                       fifoReady;

  // Clamp the low period so both high and low minima hold.
  wire [scan_pkg::CNT_W-1:0] lowReq  = (lowTime < LOW_MIN) ? LOW_MIN : lowTime;
  wire [scan_pkg::CNT_W-1:0] lowMax  = PER - HIGH_MIN;
  wire [scan_pkg::CNT_W-1:0] lowUse  = (lowReq > lowMax) ? lowMax : lowReq;
  wire [scan_pkg::CNT_W-1:0] highEnd = PER - lowLatch_ff;
  wire                       wrap    = (phase_ff == PER - scan_pkg::CNT_W'(1));
  wire [scan_pkg::CNT_W-1:0] nxtPhase = wrap ? '0 : phase_ff + scan_pkg::CNT_W'(1);
  wire                       capture = link.trigStrobe &&
                                       (trigCnt_ff >= scan_pkg::CNT_W'(scan_pkg::FIRST_VALID - 1)) &&
                                       (trigCnt_ff < scan_pkg::CNT_W'(scan_pkg::FIRST_VALID - 1 + PIXELS));

  // Period counter: start high through phases 1 to highEnd, low for the rest.
  // The line is set from the coming phase, so the high time is exactly PER minus the low time.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_ff    <= '0;
      lowLatch_ff <= LOW_MIN;
      start_ff    <= 1'b0;
    end else if (!enable && phase_ff == '0) begin
      start_ff <= 1'b0;
    end else begin
      phase_ff <= nxtPhase;
      if (phase_ff == '0) begin
        lowLatch_ff <= lowUse;
      end
      start_ff <= (nxtPhase != '0) && (nxtPhase <= highEnd);
    end
  end

  // Strobe counter: counts strobe cycles after the fall, captures from strobe 50.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trigCnt_ff  <= '0;
      over_ff     <= 1'b0;
    end else begin
      if (start_ff) begin
        trigCnt_ff <= '0;
      end else if (link.trigStrobe) begin
        trigCnt_ff <= trigCnt_ff + scan_pkg::CNT_W'(1);
      end
      if (capture && !fifoReady) begin
        over_ff <= 1'b1;
      end
    end
  end

  // Captured samples queue here so the consumer may stall.
  scan_fifo #(
    .WIDTH (scan_pkg::SAMPLE_W),
    .DEPTH (scan_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (capture),
    .inReady  (fifoReady),
    .inData   (link.video),
    .outValid (pixValid),
    .outReady (pixReady),
    .outData  (pixData)
  );

  assign link.scanStartPulse = start_ff;
  assign overflow            = over_ff;
endmodule
`default_nettype wire

// >>> scan_link_sva.sv
// Assertions on the link between the sensor end and the controller end.
`timescale 1ns/10ps
`default_nettype none
module scan_link_sva #(
  parameter int PIXELS = 8
) (
  input wire logic                          mclk,           // Scan clock.
  input wire logic                          rst_n,          // Synchronous reset.
  input wire logic                          scanStartPulse, // Start pulse.
  input wire logic                          trigStrobe,     // Sample strobe.
  input wire logic                          scanEndFlag,    // End-of-scan flag.
  input wire logic [scan_pkg::SAMPLE_W-1:0] video           // Video sample.
);
  logic [15:0] stepCnt_ff;
  logic [15:0] lowCnt_ff;
  wire  [15:0] lastStep = 16'h30 + 16'(PIXELS);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Counts strobe steps since the start pulse and clocks spent low, capped at the low minimum.
  always_ff @(posedge mclk) begin
    stepCnt_ff <= (!rst_n || scanStartPulse) ? 16'h0 : stepCnt_ff + {15'h0, trigStrobe};
    lowCnt_ff  <= !rst_n ? 16'h40 : scanStartPulse ? 16'h0 : lowCnt_ff + {15'h0, lowCnt_ff < 16'h40};
  end
  AST_SHIFT_START: assert property ($fell(scanStartPulse) |=> trigStrobe)
    else $error("strobe did not follow the start fall");
  AST_HOLD_IN_START: assert property (scanStartPulse && $past(scanStartPulse) |-> !trigStrobe)
    else $error("strobe high while start held");
  AST_HIGH_MIN: assert property ($rose(scanStartPulse) |-> scanStartPulse [*6])
    else $error("start high too short");
  AST_LOW_MIN: assert property ($rose(scanStartPulse) |-> lowCnt_ff >= 16'h40)
    else $error("start low too short");
  AST_FIRST_SAMPLE: assert property (trigStrobe && stepCnt_ff == 16'h31 |-> video == '0)
    else $error("first sample not at step fifty");
  AST_VIDEO_STEP: assert property (trigStrobe && stepCnt_ff > 16'h31 && stepCnt_ff <= lastStep
    |-> video == $past(video) + 12'h1)
    else $error("video did not advance by one");
  AST_END_COUNT: assert property (scanEndFlag |-> trigStrobe && stepCnt_ff == lastStep)
    else $error("end flag at wrong step");
  AST_END_PULSE: assert property (scanEndFlag |=> !scanEndFlag && !trigStrobe)
    else $error("end flag or strobe stayed high");
  AST_STROBE_RUN: assert property (trigStrobe && !scanEndFlag && !scanStartPulse |=> trigStrobe)
    else $error("strobe dropped mid-scan");
  AST_VIDEO_IDLE: assert property (!trigStrobe |-> video == '0)
    else $error("video not zero outside strobe");
endmodule
`default_nettype wire

// >>> linear_sensor_scan_timing_tb.sv
// Self-checking bench for the sensor and controller ends of the scan link.
`timescale 1ns/10ps
`default_nettype none
module linear_sensor_scan_timing_tb;
  localparam int PIX = 8;
  localparam int PER = 128;
  logic        mclk, rst_n, enable, pixReady, pixValid, overflow, integDone, integDone2, startDrv;
  logic [15:0] lowTime, integTime, integTime2;
  logic [11:0] pixData;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;
  scan_link_if link ();
  scan_link_if link2 ();
  assign link2.scanStartPulse = startDrv;
  scan_sensor #(.PIXELS(PIX)) u_scan_sensor (.mclk(mclk), .rst_n(rst_n), .link(link),
    .integTime(integTime), .integDone(integDone));
  scan_sensor #(.PIXELS(PIX)) u_scan_sensor_bare (.mclk(mclk), .rst_n(rst_n), .link(link2),
    .integTime(integTime2), .integDone(integDone2));
  scan_ctrl #(.PERIOD(PER), .PIXELS(PIX)) u_scan_ctrl (.mclk(mclk), .rst_n(rst_n), .link(link),
    .enable(enable), .lowTime(lowTime), .pixData(pixData), .pixValid(pixValid), .pixReady(pixReady),
    .overflow(overflow));
  scan_link_sva #(.PIXELS(PIX)) u_scan_link_sva (.mclk(mclk), .rst_n(rst_n),
    .scanStartPulse(link.scanStartPulse), .trigStrobe(link.trigStrobe),
    .scanEndFlag(link.scanEndFlag), .video(link.video));
  // Clock and hang guard.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_integ();
    int n;
    n = 0;
    step(1);
    while (integDone !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    check("integDone", {15'h0, integDone}, 16'h1);
  endtask
  // Takes n samples; the expected value restarts at zero after split samples.
  task automatic collect(input int n, input int split);
    int i;
    int w;
    i = 0;
    w = 0;
    while (i < n && w < 400) begin
      if (pixValid === 1'b1) begin
        check("pixData", {4'h0, pixData}, 16'(i < split ? i : i - split));
        i++;
      end
      step(1);
      w++;
    end
    check("pixCount", 16'(i), 16'(n));
  endtask
  task automatic scan_normal();
    wait_integ();
    check("integTime", integTime, 16'(PER - 100 + 34));
    collect(PIX, PIX);
    check("overflow", {15'h0, overflow}, 16'h0);
  endtask
  // Out-of-range low periods are clamped to the legal split.
  task automatic scan_clamp();
    lowTime = 16'h0;
    wait_integ();
    wait_integ();
    check("integTime", integTime, 16'(PER - 64 + 34));
    lowTime = 16'hffff;
    wait_integ();
    wait_integ();
    check("integTime", integTime, 16'h28);
  endtask
  // Consumer stalls; the buffer fills, drops samples, then drains in order.
  task automatic scan_stall();
    lowTime = 16'h64;
    pixReady = 1'b0;
    wait_integ();
    wait_integ();
    check("overflow", {15'h0, overflow}, 16'h1);
    pixReady = 1'b1;
    collect(12, 4);
  endtask
  // Enable low parks the start line; a reset while parked clears outputs and the sticky flag.
  task automatic pause_reset();
    logic seenHigh;
    enable = 1'b0;
    step(PER + 2);
    seenHigh = 1'b0;
    repeat (PER) begin
      step(1);
      seenHigh = seenHigh | link.scanStartPulse;
    end
    check("startParked", {15'h0, seenHigh}, 16'h0);
    rst_n = 1'b0;
    step(2);
    check("rstTrig", {15'h0, link.trigStrobe}, 16'h0);
    check("rstEnd", {15'h0, link.scanEndFlag}, 16'h0);
    check("rstInteg", integTime, 16'h0);
    check("rstOverflow", {15'h0, overflow}, 16'h0);
    check("rstValid", {15'h0, pixValid}, 16'h0);
    rst_n = 1'b1;
    enable = 1'b1;
    scan_normal();
  endtask
  // Bench drives a bare sensor: exact start timing, then a restart mid-scan.
  task automatic direct_drive();
    startDrv = 1'b1;
    step(10);
    startDrv = 1'b0;
    check("strobeEarly", {15'h0, link2.trigStrobe}, 16'h0);
    step(1);
    check("strobeFirst", {15'h0, link2.trigStrobe}, 16'h1);
    step(8);
    check("integTime2", integTime2, 16'h2c);
    startDrv = 1'b1;
    step(2);
    check("strobeAbort", {15'h0, link2.trigStrobe}, 16'h0);
    step(6);
    startDrv = 1'b0;
  endtask
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    enable = 1'b1;
    pixReady = 1'b1;
    lowTime = 16'h64;
    startDrv = 1'b0;
    step(2);
    rst_n = 1'b1;
    scan_normal();
    scan_clamp();
    scan_stall();
    pause_reset();
    direct_drive();
    give_verdict();
  end
endmodule
`default_nettype wire
